//--- logic/bit_ops_and_literal_and_exec.sv
// Operation
// - top nibble 1110 ANDs literal into accumulator
// - result to accumulator, zero flag updated, one cycle
// - 0101 sets selected bit of file register
// - 0111 tests bit, skips next when one
// - taken skip-if-one discards prefetched word as no-op
// - test-and-skip takes one cycle, two when taken
// - 0110 tests bit, skips next when zero
// - taken skip-if-zero discards prefetched word, extra cycle
// - low five bits file, next three bit
`timescale 1ns/10ps
`default_nettype none
`include "bit_ops_map.svh"
module bit_ops_and_literal_and_exec
   import bit_ops_pkg::*;
(
   input wire logic sys_clk_i, // core clock, 250 MHz
   input wire logic rst_i, // synchronous reset, active high
   input wire logic [`INSTR_W-1:0] instr_i, // fetched instruction word
   input wire logic instr_valid_i, // instruction word present this cycle
   input wire file_idx_t rd_addr_i, // file register read-back index
   output byte_t acc_o, // working accumulator
   output logic zero_o, // zero flag
   output byte_t rd_data_o, // file register read-back data
   output logic retired_o, // pulse: a handled instruction executed
   output logic discard_o, // pulse: prefetched word replaced by no-op
   output logic skip_taken_o, // pulse: a test-and-skip succeeded
   output logic unhandled_o // pulse: word outside this block's set
);

   // opcode classification; every word in a single program word
   function automatic op_kind_t decode_op(input logic [`INSTR_W-1:0] word);
      logic [3:0] opc;
      opc = word[`OPC_HI:`OPC_LO];
      unique case (opc)
         `OPC_AND_LIT: decode_op = OP_AND_LIT;
         `OPC_BIT_CLR: decode_op = OP_BIT_CLR;
         `OPC_BIT_SET: decode_op = OP_BIT_SET;
         `OPC_SKIP_ONE: decode_op = OP_SKIP_ONE;
         `OPC_SKIP_ZERO: decode_op = OP_SKIP_ZERO;
         default: decode_op = OP_NONE; // other opcodes belong elsewhere
      endcase
   endfunction : decode_op

   // architectural state
   byte_t acc; // working accumulator
   logic zero; // zero flag, the only status flag held here
   byte_t file_q [`FILE_COUNT]; // file registers as flip-flops
   exec_state_t state; // run or discard the next word
   exec_state_t next_state; // state for the next cycle

   // decoded fields of the current word
   op_kind_t kind; // class of the current word
   byte_t lit; // eight-bit literal
   bit_idx_t bit_idx; // selected bit position
   file_idx_t file_idx; // selected file register
   byte_t file_rd; // contents of the selected file register
   logic sel_bit; // value of the selected bit
   byte_t set_val; // file byte with bit set
   byte_t clr_val; // file byte with bit cleared

   // qualified actions
   logic execute; // a word is executed this cycle
   logic flush; // a word is being thrown away this cycle
   logic is_bit_op; // set, clear or test class
   logic test_hit; // a test-and-skip condition holds
   logic file_we; // file register write this cycle
   byte_t file_wdata; // byte written back
   byte_t and_res; // accumulator AND literal
   logic and_we; // accumulator write this cycle

   // field extraction
   assign kind = decode_op(instr_i);
   assign lit = instr_i[`LIT_HI:`LIT_LO];
   assign bit_idx = instr_i[`BIT_HI:`BIT_LO];
   assign file_idx = instr_i[`FILE_HI:`FILE_LO];
   // combinational read of the addressed byte for read-modify-write
   assign file_rd = file_q[file_idx];

   // bit manipulation on the addressed byte
   bit_select u_bit_select (
      .byte_i(file_rd),
      .bit_idx_i(bit_idx),
      .bit_o(sel_bit),
      .set_o(set_val),
      .clr_o(clr_val)
   );

   // a word arriving while discarding is never executed, so the
   // skipped instruction has no side effect at all
   assign execute = instr_valid_i && (state == EXEC_RUN);
   assign flush = instr_valid_i && (state == EXEC_FLUSH);

   // every bit-oriented word this block retires falls in one of these
   assign is_bit_op = (kind == OP_BIT_CLR) || (kind == OP_BIT_SET) ||
                      (kind == OP_SKIP_ONE) || (kind == OP_SKIP_ZERO);

   // skip conditions of both test flavours
   assign test_hit = ((kind == OP_SKIP_ONE) && sel_bit) ||
                     ((kind == OP_SKIP_ZERO) && !sel_bit);

   // a test reads the byte but never writes it back
   // read-modify-write of one file register in a single cycle
   assign file_we = execute && ((kind == OP_BIT_SET) || (kind == OP_BIT_CLR));
   assign file_wdata = (kind == OP_BIT_SET) ? set_val : clr_val;

   // literal AND into the accumulator
   assign and_res = acc & lit;
   assign and_we = execute && (kind == OP_AND_LIT);

   // a taken test discards exactly the next valid word, idle gaps between; an untaken one stays
   // in run, so the next word executes right away
   always_comb
   begin
      next_state = state;
      unique case (state)
         EXEC_RUN:
         begin
            // arm the discard of the already prefetched word
            if (execute && test_hit)
            begin
               next_state = EXEC_FLUSH;
            end
            else
            begin
               next_state = EXEC_RUN; // untaken test or any other word
            end
         end
         EXEC_FLUSH:
         begin
            // the no-op cycle ends once the discarded word has gone by
            if (flush)
            begin
               next_state = EXEC_RUN;
            end
            else
            begin
               next_state = EXEC_FLUSH; // idle gaps keep the discard armed
            end
         end
      endcase
   end

   // execution state register
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state <= EXEC_RUN;
      end
      else
      begin
         state <= next_state;
      end
   end

   // accumulator and zero flag change only on the literal AND; bit
   // instructions never reach this process
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         // reset leaves a nonzero accumulator, so the flag starts clear
         acc <= `ACC_RST;
         zero <= `ZERO_RST;
      end
      else if (and_we)
      begin
         acc <= and_res;
         zero <= (and_res == 8'h00);
      end
   end

   // file registers, one write-enabled byte per index; the flag is kept
   // apart from this array so bit instructions cannot touch it
   genvar g;
   generate
      for (g = 0; g < `FILE_COUNT; g = g + 1)
      begin : g_file
         always_ff @(posedge sys_clk_i)
         begin
            if (rst_i)
            begin
               file_q[g] <= `FILE_RST;
            end
            else if (file_we && (file_idx == file_idx_t'(g)))
            begin
               file_q[g] <= file_wdata;
            end
         end
      end
   endgenerate

   // registered outputs; read-back lags the index by one cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         rd_data_o <= `FILE_RST;
         retired_o <= 1'b0;
         discard_o <= 1'b0;
         skip_taken_o <= 1'b0;
         unhandled_o <= 1'b0;
      end
      else
      begin
         rd_data_o <= file_q[rd_addr_i];
         // a taken test retires itself; the word it throws away does not
         // each handled word retires in one cycle as a single word
         retired_o <= execute && (is_bit_op || (kind == OP_AND_LIT));
         discard_o <= flush;
         skip_taken_o <= execute && test_hit;
         // words of other units leave no trace beyond this pulse
         unhandled_o <= execute && (kind == OP_NONE);
      end
   end

   // accumulator and flag leave straight from their flip-flops
   assign acc_o = acc;
   assign zero_o = zero;

endmodule : bit_ops_and_literal_and_exec
`default_nettype wire

//--- logic/bit_ops_map.svh
`ifndef BIT_OPS_MAP_SVH
`define BIT_OPS_MAP_SVH

// instruction word layout
`define INSTR_W 12
`define OPC_HI 11
`define OPC_LO 8
`define LIT_HI 7
`define LIT_LO 0
`define BIT_HI 7
`define BIT_LO 5
`define FILE_HI 4
`define FILE_LO 0

// top-nibble opcode patterns
`define OPC_AND_LIT 4'hE
`define OPC_BIT_CLR 4'h4
`define OPC_BIT_SET 4'h5
`define OPC_SKIP_ZERO 4'h6
`define OPC_SKIP_ONE 4'h7

// storage sizes and reset values
`define FILE_COUNT 32
// all ones is the identity of the AND, so the first literal loads itself
`define ACC_RST 8'hFF
`define ZERO_RST 1'h0
`define FILE_RST 8'h00

// cycle counts of a bit-test-and-skip
`define SKIP_CYCLES_NOT_TAKEN 1
`define SKIP_CYCLES_TAKEN 2

`endif

//--- logic/bit_ops_pkg.sv
`default_nettype none
package bit_ops_pkg;
   // one data byte of the accumulator or a file register
   typedef logic [7:0] byte_t;
   // five-bit file register index
   typedef logic [4:0] file_idx_t;
   // three-bit bit position
   typedef logic [2:0] bit_idx_t;
   // decoded instruction class
   typedef enum logic [2:0] {
      OP_NONE,
      OP_AND_LIT,
      OP_BIT_CLR,
      OP_BIT_SET,
      OP_SKIP_ONE,
      OP_SKIP_ZERO
   } op_kind_t;
   // execution state: normal run or discarding the prefetched word
   typedef enum logic {
      EXEC_RUN,
      EXEC_FLUSH
   } exec_state_t;
endpackage : bit_ops_pkg
`default_nettype wire

//--- logic/bit_select.sv
`timescale 1ns/10ps
`default_nettype none
module bit_select
   import bit_ops_pkg::*;
(
   input wire byte_t byte_i, // byte read from the file register
   input wire bit_idx_t bit_idx_i, // bit position to act on
   output logic bit_o, // selected bit value
   output byte_t set_o, // byte with selected bit forced to one
   output byte_t clr_o // byte with selected bit forced to zero
);
   // one-hot mask of the selected bit
   byte_t mask;

   // one decoder per bit position
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_mask
         assign mask[i] = (bit_idx_i == bit_idx_t'(i));
      end
   endgenerate

   // only the masked bit changes, every other bit passes through
   assign set_o = byte_i | mask;
   assign clr_o = byte_i & ~mask;
   assign bit_o = |(byte_i & mask);
endmodule : bit_select
`default_nettype wire

//--- tb/bit_ops_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "bit_ops_map.svh"
module bit_ops_assertions
   import bit_ops_pkg::*;
(
   input wire logic sys_clk_i, // core clock
   input wire logic rst_i, // synchronous reset
   input wire logic [`INSTR_W-1:0] instr_i, // fetched word
   input wire logic instr_valid_i, // word present
   input wire file_idx_t rd_addr_i, // read-back index
   input wire byte_t acc_o, // accumulator
   input wire logic zero_o, // zero flag
   input wire byte_t rd_data_o, // read-back data
   input wire logic retired_o, // executed pulse
   input wire logic discard_o, // discarded pulse
   input wire logic skip_taken_o, // skip pulse
   input wire logic unhandled_o // other opcode pulse
);
   logic pend; // skip armed, no word taken yet
   wire logic [3:0] opc = instr_i[`OPC_HI:`OPC_LO]; // opcode nibble
   wire logic run = !(skip_taken_o || pend); // next taken word executes
   wire logic go = instr_valid_i && run; // executing take
   wire logic bitop = opc inside {`OPC_BIT_CLR, `OPC_BIT_SET, `OPC_SKIP_ZERO, `OPC_SKIP_ONE};
   wire logic next_pend = (skip_taken_o || pend) && !instr_valid_i; // gaps keep the flush
   // gaps do not end a flush, so the armed skip is remembered here
   always_ff @(posedge sys_clk_i)
   begin
      pend <= rst_i ? 1'b0 : next_pend;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   and_result_a:
   assert property (go && opc == `OPC_AND_LIT |=> acc_o == ($past(acc_o) & $past(instr_i[7:0]))
      && zero_o == (acc_o == 8'h00)) else $error("and literal result wrong");
   zero_hold_a:
   assert property (!(go && opc == `OPC_AND_LIT) |=> $stable(zero_o)) else $error("zero moved");
   acc_hold_a:
   assert property (go && bitop |=> $stable(acc_o)) else $error("bit op moved acc");
   retire_once_a:
   assert property (go && (bitop || opc == `OPC_AND_LIT) |=> retired_o && !unhandled_o
      && !discard_o) else $error("handled word not retired in one cycle");
   skip_cause_a:
   assert property (skip_taken_o |-> $past(go) && $past(opc == `OPC_SKIP_ONE
      || opc == `OPC_SKIP_ZERO)) else $error("skip without test");
   discard_word_a:
   assert property (instr_valid_i && !run |=> discard_o && !retired_o && !skip_taken_o
      && $stable(acc_o)) else $error("prefetched word not discarded");
   set_seen_a:
   assert property (go && opc == `OPC_BIT_SET && rd_addr_i == instr_i[4:0] ##1 !instr_valid_i
      && $stable(rd_addr_i) |=> rd_data_o[$past(instr_i[7:5], 2)]) else $error("bit not set");
   clr_seen_a:
   assert property (go && opc == `OPC_BIT_CLR && rd_addr_i == instr_i[4:0] ##1 !instr_valid_i
      && $stable(rd_addr_i) |=> !rd_data_o[$past(instr_i[7:5], 2)]) else $error("bit not clear");
   cover property (skip_taken_o);
   cover property (discard_o);
   cover property (unhandled_o);
endmodule : bit_ops_assertions
bind bit_ops_and_literal_and_exec bit_ops_assertions chk (.sys_clk_i, .rst_i, .instr_i,
   .instr_valid_i, .rd_addr_i, .acc_o, .zero_o, .rd_data_o, .retired_o, .discard_o,
   .skip_taken_o, .unhandled_o);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb
   import bit_ops_pkg::*;
;
   logic sys_clk_i = 1'b0; // core clock
   logic rst_i = 1'b1; // reset held at start
   logic [11:0] instr_i = 12'h000; // word driven
   logic instr_valid_i = 1'b0; // word present
   file_idx_t rd_addr_i = 5'h03; // every test works on file 3
   byte_t acc_o, rd_data_o; // data outputs
   logic zero_o, retired_o, discard_o, skip_taken_o, unhandled_o; // flags
   int errors = 0; // mismatches
   int n_tests = 0; // comparisons
   bit_ops_and_literal_and_exec dut (.sys_clk_i, .rst_i, .instr_i, .instr_valid_i, .rd_addr_i,
      .acc_o, .zero_o, .rd_data_o, .retired_o, .discard_o, .skip_taken_o, .unhandled_o);
   // free-running 4 ns clock
   initial forever #2 sys_clk_i = ~sys_clk_i;
   task final_report;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // valid stays high so calls in a row are back to back
   task op(input logic [11:0] w);
      instr_i = w;
      instr_valid_i = 1'b1;
      @(negedge sys_clk_i);
   endtask : op
   // two quiet edges let a write reach the read-back port
   task idle;
      instr_valid_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
   endtask : idle
   task t_and;
      op(12'hEA3);
      `CHK("acc first", 8'hA3, acc_o);
      `CHK("retired", 1'b1, retired_o);
      `CHK("zero clear", 1'b0, zero_o);
      op(12'hE5F);
      `CHK("acc", 8'h03, acc_o);
      op(12'hE0C);
      `CHK("acc zero", 8'h00, acc_o);
      `CHK("zero", 1'b1, zero_o);
      idle;
   endtask : t_and
   task t_bits;
      op(12'h5E3);
      op(12'h523);
      idle;
      `CHK("set", 8'h82, rd_data_o);
      op(12'h4E3);
      idle;
      `CHK("clr", 8'h02, rd_data_o);
      `CHK("zero kept", 1'b1, zero_o);
   endtask : t_bits
   task t_skip;
      // a second reset mid-run brings back acc, flag and file registers
      rst_i = 1'b1;
      instr_valid_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      `CHK("acc reset", 8'hFF, acc_o);
      `CHK("zero reset", 1'b0, zero_o);
      op(12'h7E3);
      `CHK("no skip", 1'b0, skip_taken_o);
      op(12'h5E3);
      `CHK("no discard", 1'b0, discard_o);
      op(12'h7E3);
      `CHK("skip one", 1'b1, skip_taken_o);
      op(12'h4E3);
      `CHK("discard", 1'b1, discard_o);
      `CHK("no retire", 1'b0, retired_o);
      op(12'h663);
      `CHK("skip zero", 1'b1, skip_taken_o);
      instr_valid_i = 1'b0;
      @(negedge sys_clk_i);
      op(12'h563);
      `CHK("discard gap", 1'b1, discard_o);
      op(12'h6E3);
      `CHK("bit one kept", 1'b0, skip_taken_o);
      op(12'hF00);
      `CHK("other", 1'b1, unhandled_o);
      `CHK("acc kept", 8'hFF, acc_o);
      idle;
      `CHK("after skips", 8'h80, rd_data_o);
   endtask : t_skip
   // main sequence after sixteen reset cycles
   initial
   begin
      repeat (16) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_and;
      t_bits;
      t_skip;
      final_report;
   end
   // the run needs well under a hundred cycles
   initial
   begin
      #4000;
      errors++;
      final_report;
   end
endmodule : tb
`default_nettype wire
